// ### src/ccs_clock_sequencer.sv
// clock set-up sequencer: registers, pll lock model, link clock outputs, adc/dac gating
// Overview of operation
// - pll runs after power bit rises with master clock in toggling; lock within 10ms
// - master mode drives frame and bit clocks only after pll is stable
// - unlocked pll with master clock output enabled gives an unreliable clock
// - locked pll with master clock output enabled gives the correct clock
// - pll referenced to frame clock locks within 160ms
// - pll referenced to bit clock locks within 2ms
// - external slave mode runs once master, frame and bit clocks are present
// - dac words are two's complement: 7FFFFF high, 800000 low, 000000 mid
// - adc power-up runs 1059 sample periods of zero output unless fast init
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"

module ccs_clock_sequencer #(
    parameter int unsigned LOCK_MASTER_CLOCK_IN_CYC = `CCS_LOCK_MASTER_CLOCK_IN_MS * `CCS_CLK_KHZ,
    parameter int unsigned LOCK_FRAME_CYC = `CCS_LOCK_FRAME_MS * `CCS_CLK_KHZ,
    parameter int unsigned LOCK_BIT_CYC = `CCS_LOCK_BIT_MS * `CCS_CLK_KHZ,
    parameter int unsigned REF_WINDOW_CYC = `CCS_REF_WINDOW_CYC
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // link clock and reset pin
    input wire logic master_clock_in,
    input wire logic reset_low_pin,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // two-way audio clocks
    input wire logic frame_clock_i,
    output logic frame_clock_o,
    output logic frame_clock_oe,
    input wire logic bit_clock_i,
    output logic bit_clock_o,
    output logic bit_clock_oe,
    // master clock output and status
    output logic master_clock_out,
    output logic master_clock_out_valid,
    output logic pll_locked,
    output logic normal_op,
    // configuration towards the audio path
    output logic [1:0] audio_format_sel,
    output logic [3:0] sample_rate_sel,
    output logic [3:0] pll_ref_freq_sel,
    // sample paths
    input wire logic [23:0] dac_word,
    output logic [23:0] dac_code,
    input wire logic [23:0] adc_word,
    output logic [23:0] serial_data_out,
    output logic adc_init_busy
);

    localparam logic [3:0] RESET_LOW_CYC = 4'(`CCS_RESET_LOW_CYC);

    // ****************************************
    // helpers
    // ****************************************
    function automatic int unsigned lock_limit(input ccs_pkg::ccs_clk_mode_t m);
        unique case (m)
            ccs_pkg::CCS_CM_PLL_SLAVE_FRAME: lock_limit = LOCK_FRAME_CYC;
            ccs_pkg::CCS_CM_PLL_SLAVE_BIT: lock_limit = LOCK_BIT_CYC;
            default: lock_limit = LOCK_MASTER_CLOCK_IN_CYC;
        endcase
    endfunction

    function automatic logic [1:0] ref_index(input ccs_pkg::ccs_clk_mode_t m);
        unique case (m)
            ccs_pkg::CCS_CM_PLL_SLAVE_FRAME: ref_index = 2'h1;
            ccs_pkg::CCS_CM_PLL_SLAVE_BIT: ref_index = 2'h2;
            default: ref_index = 2'h0;
        endcase
    endfunction

    // ****************************************
    // pin synchronisers (mclk toggle, frame, bit, reset pin)
    // ****************************************
    logic mck_toggle;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [3:0] stab;
    logic [3:0] low_cnt;
    logic pin_rst;
    logic dev_rst;
    logic [2:0] ev;

    always_ff @(posedge clk) begin
        if (rst) begin
            // idle levels: reset pin high, frame and bit pulled up, no false edge
            sy1 <= 4'hE;
            sy2 <= 4'hE;
            sy3 <= 4'hE;
            stab <= 4'hE;
        end else begin
            sy1 <= {reset_low_pin, bit_clock_i, frame_clock_i, mck_toggle};
            sy2 <= sy1;
            sy3 <= sy2;
            for (int k = 0; k < 4; k++) begin
                if (sy2[k] == sy3[k]) begin
                    stab[k] <= sy3[k];
                end
            end
        end
    end

    // events: mclk any change, frame rise, bit rise
    assign ev[0] = (sy2[0] == sy3[0]) && (sy3[0] != stab[0]);
    assign ev[1] = sy2[1] && sy3[1] && !stab[1];
    assign ev[2] = sy2[2] && sy3[2] && !stab[2];

    // pin reset taken once low for the minimum low time
    always_ff @(posedge clk) begin
        if (rst || stab[3]) begin
            low_cnt <= 4'h0;
        end else if (low_cnt != RESET_LOW_CYC) begin
            low_cnt <= low_cnt + 4'h1;
        end
    end

    assign pin_rst = (low_cnt == RESET_LOW_CYC);
    assign dev_rst = rst || pin_rst;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] power_reg;
    logic [7:0] mode_reg;
    logic [7:0] pll_reg;
    logic [7:0] rate_reg;
    logic seq_err;
    logic wr_power;
    logic vref_on;
    logic eff_pll;
    logic eff_adc;
    logic eff_dac;
    ccs_pkg::ccs_clk_mode_t clk_mode;

    assign wr_power = reg_wr && (reg_addr == `CCS_ADDR_POWER);

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            power_reg <= `CCS_POWER_RST;
            mode_reg <= `CCS_MODE_RST;
            pll_reg <= `CCS_PLL_RST;
            rate_reg <= `CCS_RATE_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `CCS_ADDR_POWER: power_reg <= reg_wdata;
                `CCS_ADDR_MODE: mode_reg <= reg_wdata;
                `CCS_ADDR_PLL: pll_reg <= reg_wdata;
                `CCS_ADDR_RATE: rate_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // sticky: block enabled while common reference off; set beats write-one clear
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            seq_err <= 1'b0;
        end else if (wr_power && !power_reg[`CCS_PWR_VREF_BIT]
                     && (reg_wdata[3:1] != 3'h0)) begin
            seq_err <= 1'b1;
        end else if (reg_wr && (reg_addr == `CCS_ADDR_STATUS)
                     && reg_wdata[`CCS_STAT_SEQERR_BIT]) begin
            seq_err <= 1'b0;
        end
    end

    assign vref_on = power_reg[`CCS_PWR_VREF_BIT];
    assign eff_pll = vref_on && power_reg[`CCS_PWR_PLL_BIT];
    assign eff_adc = vref_on && power_reg[`CCS_PWR_ADC_BIT];
    assign eff_dac = vref_on && power_reg[`CCS_PWR_DAC_BIT];
    assign clk_mode = ccs_pkg::ccs_clk_mode_t'(pll_reg[`CCS_PLL_CMODE_LSB +: 3]);
    assign audio_format_sel = mode_reg[`CCS_MODE_FMT_LSB +: 2];
    assign sample_rate_sel = rate_reg[`CCS_RATE_SEL_LSB +: 4];
    assign pll_ref_freq_sel = pll_reg[`CCS_PLL_SEL_LSB +: 4];

    // ****************************************
    // clock presence monitors
    // ****************************************
    logic [15:0] alive_cnt [3];
    logic [2:0] alive;

    always_ff @(posedge clk) begin
        for (int k = 0; k < 3; k++) begin
            if (dev_rst) begin
                alive_cnt[k] <= 16'h0000;
            end else if (ev[k]) begin
                alive_cnt[k] <= 16'(REF_WINDOW_CYC);
            end else if (alive_cnt[k] != 16'h0000) begin
                alive_cnt[k] <= alive_cnt[k] - 16'h0001;
            end
        end
    end

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            alive[k] = (alive_cnt[k] != 16'h0000);
        end
    end

    // ****************************************
    // pll start and lock model
    // ****************************************
    logic pll_prev;
    logic pll_run;
    logic ref_ok;
    logic lock_q;
    logic [31:0] lock_cnt;
    logic ext_mode;

    assign ext_mode = (clk_mode != ccs_pkg::CCS_CM_PLL_MASTER)
                      && (clk_mode != ccs_pkg::CCS_CM_PLL_SLAVE_FRAME)
                      && (clk_mode != ccs_pkg::CCS_CM_PLL_SLAVE_BIT)
                      && (clk_mode != ccs_pkg::CCS_CM_PLL_SLAVE_MASTER_CLOCK_IN);
    assign ref_ok = alive[ref_index(clk_mode)];

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            pll_prev <= 1'b0;
            pll_run <= 1'b0;
        end else begin
            pll_prev <= eff_pll;
            if (!eff_pll || ext_mode) begin
                pll_run <= 1'b0;
            end else if (!pll_prev) begin
                pll_run <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (dev_rst || !pll_run || !ref_ok) begin
            lock_cnt <= 32'h0;
            lock_q <= 1'b0;
        end else if (!lock_q) begin
            if (lock_cnt >= lock_limit(clk_mode) - 32'h1) begin
                lock_q <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 32'h1;
            end
        end
    end

    assign pll_locked = lock_q;
    assign master_clock_out_valid = lock_q && mode_reg[`CCS_MODE_MCO_BIT];

    // ****************************************
    // sequence state machine
    // ****************************************
    ccs_pkg::ccs_state_t state;
    ccs_pkg::ccs_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            ccs_pkg::CCS_ST_IDLE: begin
                if (vref_on) begin
                    next_state = ccs_pkg::CCS_ST_VREF;
                end
            end
            ccs_pkg::CCS_ST_VREF: begin
                if (ext_mode && (alive == 3'h7)) begin
                    next_state = ccs_pkg::CCS_ST_NORMAL;
                end else if (pll_run) begin
                    next_state = ccs_pkg::CCS_ST_LOCK;
                end
            end
            ccs_pkg::CCS_ST_LOCK: begin
                if (lock_q) begin
                    next_state = ccs_pkg::CCS_ST_NORMAL;
                end else if (!pll_run) begin
                    next_state = ccs_pkg::CCS_ST_VREF;
                end
            end
            ccs_pkg::CCS_ST_NORMAL: begin
                if (ext_mode ? (alive != 3'h7) : !lock_q) begin
                    next_state = pll_run ? ccs_pkg::CCS_ST_LOCK : ccs_pkg::CCS_ST_VREF;
                end
            end
            default: next_state = ccs_pkg::CCS_ST_IDLE;
        endcase
        if (!vref_on) begin
            next_state = ccs_pkg::CCS_ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            state <= ccs_pkg::CCS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign normal_op = (state == ccs_pkg::CCS_ST_NORMAL);

    // ****************************************
    // adc initialisation and output
    // ****************************************
    logic adc_prev;
    logic [10:0] init_cnt;

    always_ff @(posedge clk) begin
        if (dev_rst || !eff_adc) begin
            adc_prev <= 1'b0;
            init_cnt <= 11'h000;
        end else begin
            adc_prev <= 1'b1;
            if (!adc_prev) begin
                init_cnt <= rate_reg[`CCS_RATE_FAST_BIT] ? 11'(`CCS_ADC_INIT_FAST_FS)
                                                         : 11'(`CCS_ADC_INIT_FS);
            end else if (ev[1] && (init_cnt != 11'h000)) begin
                init_cnt <= init_cnt - 11'h001;
            end
        end
    end

    assign adc_init_busy = eff_adc && (!adc_prev || (init_cnt != 11'h000));

    // zero data while powered down, initialising or without clocks
    always_ff @(posedge clk) begin
        if (dev_rst || adc_init_busy || !eff_adc || !normal_op) begin
            serial_data_out <= 24'h000000;
        end else begin
            serial_data_out <= adc_word;
        end
    end

    // ****************************************
    // dac: two's complement to offset code
    // ****************************************
    always_ff @(posedge clk) begin
        if (dev_rst || !eff_dac || !normal_op) begin
            dac_code <= `CCS_DAC_MID ^ `CCS_DAC_NEG_FS;
        end else begin
            dac_code <= dac_word ^ `CCS_DAC_NEG_FS;
        end
    end

    // ****************************************
    // register read
    // ****************************************
    always_ff @(posedge clk) begin
        if (dev_rst || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                `CCS_ADDR_POWER: reg_rdata <= power_reg;
                `CCS_ADDR_MODE: reg_rdata <= mode_reg;
                `CCS_ADDR_PLL: reg_rdata <= pll_reg;
                `CCS_ADDR_RATE: reg_rdata <= rate_reg;
                `CCS_ADDR_STATUS: reg_rdata <= {state, seq_err, adc_init_busy,
                                                normal_op, alive[0], lock_q};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // link clock domain
    // ****************************************
    logic mrst1;
    logic mrst2;
    logic [3:0] mcfg1;
    logic [3:0] mcfg2;
    logic [7:0] mdiv;
    logic master_sel;

    assign master_sel = (clk_mode == ccs_pkg::CCS_CM_PLL_MASTER);

    // reset and quasi-static config into the link domain
    always_ff @(posedge master_clock_in) begin
        mrst1 <= dev_rst;
        mrst2 <= mrst1;
        mcfg1 <= {lock_q, master_sel && eff_pll, mode_reg[`CCS_MODE_MCO_BIT],
                  mode_reg[`CCS_MODE_RATIO_BIT]};
        mcfg2 <= mcfg1;
    end

    always_ff @(posedge master_clock_in) begin
        if (mrst2) begin
            mck_toggle <= 1'b0;
            mdiv <= 8'h00;
        end else begin
            mck_toggle <= !mck_toggle;
            mdiv <= mdiv + 8'h01;
        end
    end

    // frame and bit clocks, driven only once locked in master mode
    always_ff @(posedge master_clock_in) begin
        if (mrst2) begin
            bit_clock_o <= 1'b0;
            frame_clock_o <= 1'b0;
            bit_clock_oe <= 1'b0;
            frame_clock_oe <= 1'b0;
        end else begin
            bit_clock_o <= mdiv[1];
            frame_clock_o <= mcfg2[0] ? mdiv[7] : mdiv[6];
            bit_clock_oe <= mcfg2[3] && mcfg2[2];
            frame_clock_oe <= mcfg2[3] && mcfg2[2];
        end
    end

    // master clock output: wrong rate until lock, correct rate after
    always_ff @(posedge master_clock_in) begin
        if (mrst2 || !mcfg2[1]) begin
            master_clock_out <= 1'b0;
        end else if (mcfg2[3]) begin
            master_clock_out <= !master_clock_out;
        end else begin
            master_clock_out <= mdiv[2];
        end
    end

endmodule

`default_nettype wire

// ### src/ccs_regs.svh
// register map, field positions, reset values and timing counts of the clock sequencer
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define CCS_ADDR_POWER 8'h00
`define CCS_ADDR_MODE 8'h01
`define CCS_ADDR_PLL 8'h02
`define CCS_ADDR_RATE 8'h03
`define CCS_ADDR_STATUS 8'h04

// ****************************************
// field positions
// ****************************************
`define CCS_PWR_VREF_BIT 0
`define CCS_PWR_PLL_BIT 1
`define CCS_PWR_ADC_BIT 2
`define CCS_PWR_DAC_BIT 3
`define CCS_MODE_FMT_LSB 0
`define CCS_MODE_RATIO_BIT 2
`define CCS_MODE_MCO_BIT 3
`define CCS_PLL_SEL_LSB 0
`define CCS_PLL_CMODE_LSB 4
`define CCS_RATE_SEL_LSB 0
`define CCS_RATE_FAST_BIT 4
`define CCS_STAT_LOCK_BIT 0
`define CCS_STAT_MASTER_CLOCK_IN_BIT 1
`define CCS_STAT_NORMAL_BIT 2
`define CCS_STAT_INIT_BIT 3
`define CCS_STAT_SEQERR_BIT 4
`define CCS_STAT_STATE_LSB 5

// ****************************************
// reset values
// ****************************************
`define CCS_POWER_RST 8'h00
`define CCS_MODE_RST 8'h00
`define CCS_PLL_RST 8'h00
`define CCS_RATE_RST 8'h00

// ****************************************
// timing
// ****************************************
`define CCS_CLK_KHZ 25000
`define CCS_CLK_PERIOD_NS 40
`define CCS_RESET_LOW_NS 150
`define CCS_RESET_LOW_CYC ((`CCS_RESET_LOW_NS + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS)
`define CCS_LOCK_MASTER_CLOCK_IN_MS 10
`define CCS_LOCK_FRAME_MS 160
`define CCS_LOCK_BIT_MS 2
`define CCS_REF_WINDOW_CYC 4096
`define CCS_ADC_INIT_FS 1059
`define CCS_ADC_INIT_FAST_FS 267

// ****************************************
// dac sample codes
// ****************************************
`define CCS_DAC_POS_FS 24'h7FFFFF
`define CCS_DAC_NEG_FS 24'h800000
`define CCS_DAC_MID 24'h000000

`endif

// ### src/ccs_pkg.sv
// types of the clock sequencer
package ccs_pkg;

    typedef enum logic [2:0] {
        CCS_CM_PLL_MASTER = 3'h0,
        CCS_CM_PLL_SLAVE_FRAME = 3'h1,
        CCS_CM_PLL_SLAVE_BIT = 3'h2,
        CCS_CM_PLL_SLAVE_MASTER_CLOCK_IN = 3'h3,
        CCS_CM_EXT_SLAVE = 3'h4
    } ccs_clk_mode_t;

    typedef enum logic [2:0] {
        CCS_ST_IDLE = 3'h0,
        CCS_ST_VREF = 3'h1,
        CCS_ST_LOCK = 3'h3,
        CCS_ST_NORMAL = 3'h2
    } ccs_state_t;

endpackage

// ### verif/ccs_clock_sequencer_properties.sv
// port checker of the clock sequencer
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_sequencer_chk #(
    parameter int unsigned LOCK_MIN_CYC = 100
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // observed ports
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic frame_clock_oe,
    input wire logic bit_clock_oe,
    input wire logic master_clock_out_valid,
    input wire logic pll_locked,
    input wire logic normal_op,
    input wire logic [23:0] dac_word,
    input wire logic [23:0] dac_code,
    input wire logic adc_init_busy,
    input wire logic [23:0] serial_data_out
);
    // ****************************************
    // unlocked cycle count and properties
    // ****************************************
    int unsigned unlk;
    always_ff @(posedge clk) begin
        if (rst || pll_locked) begin
            unlk <= 0;
        end else if (unlk < LOCK_MIN_CYC) begin
            unlk <= unlk + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_frame_up; !frame_clock_oe ##1 frame_clock_oe; endsequence
    sequence s_bit_up; !bit_clock_oe ##1 bit_clock_oe; endsequence
    chk_frame_after_lock: assert property (s_frame_up |-> pll_locked)
        else $error("frame clock driven without lock");
    chk_bit_after_lock: assert property (s_bit_up |-> pll_locked)
        else $error("bit clock driven without lock");
    chk_mco_valid_lock: assert property (master_clock_out_valid |-> pll_locked)
        else $error("master clock valid without lock");
    chk_lock_not_early: assert property ($rose(pll_locked) |-> unlk >= LOCK_MIN_CYC)
        else $error("pll locked too early");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_dac_map: assert property (dac_code == ($past(dac_word) ^ 24'h800000)
        || dac_code == 24'h800000)
        else $error("dac code not offset of word");
    chk_dac_idle: assert property (!normal_op |=> dac_code == 24'h800000)
        else $error("dac not mid scale when idle");
    chk_init_zero: assert property (adc_init_busy |=> serial_data_out == 24'h000000)
        else $error("adc data during init");
endmodule
bind ccs_clock_sequencer ccs_clock_sequencer_chk #(.LOCK_MIN_CYC(LOCK_BIT_CYC))
    ccs_clock_sequencer_chk_i (.clk, .rst, .reg_rd, .reg_rdata, .frame_clock_oe,
    .bit_clock_oe, .master_clock_out_valid, .pll_locked, .normal_op, .dac_word,
    .dac_code, .adc_init_busy, .serial_data_out);
`default_nettype wire

// ### verif/ccs_host_clk_model.sv
// host clock model: master clock source, slave audio clocks, pin levels
`timescale 1ns/1ps
`default_nettype none
module ccs_host_clk_model (
    // control
    input wire logic slv_en,
    // device drive
    input wire logic frame_o,
    input wire logic frame_oe,
    input wire logic bit_o,
    input wire logic bit_oe,
    // clocks and pins
    output logic mclk,
    output logic frame_pin,
    output logic bit_pin
);
    // ****************************************
    // clocks
    // ****************************************
    logic [3:0] div = 4'h0;
    initial begin
        mclk = 1'b0;
        #7;
        forever begin
            #32 mclk = ~mclk;
        end
    end
    always @(posedge mclk) begin
        div <= div + 4'h1;
    end
    // pull-up when nobody drives
    assign bit_pin = bit_oe ? bit_o : (slv_en ? div[0] : 1'b1);
    assign frame_pin = frame_oe ? frame_o : (slv_en ? div[3] : 1'b1);
endmodule
`default_nettype wire

// ### verif/tb_codec_clock_setup_sequencer.sv
// self-checking bench of the clock sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin fails++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_codec_clock_setup_sequencer;
    // ****************************************
    // signals and rows
    // ****************************************
    localparam int LK_M = 200;
    localparam int LK_F = 400;
    localparam int LK_B = 100;
    logic clk, rst, mclk, rlp, reg_wr, reg_rd, slv, fpin, bpin, fo, foe, bo, boe;
    logic mco, mcov, lock, nop, busy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [1:0] afs;
    logic [3:0] srs, prs;
    logic [23:0] dw, dc, aw, sdo;
    int fails = 0;
    int checked = 0;
    int n, frc;
    realtime t0;
    logic [2:0] cm [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    int lim [5] = '{LK_M, LK_F, LK_B, LK_M, 0};
    logic sl [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [23:0] dwv [3] = '{24'h7FFFFF, 24'h800000, 24'h000000};
    logic [23:0] dcv [3] = '{24'hFFFFFF, 24'h000000, 24'h800000};
    ccs_clock_sequencer #(.LOCK_MASTER_CLOCK_IN_CYC(LK_M), .LOCK_FRAME_CYC(LK_F),
        .LOCK_BIT_CYC(LK_B), .REF_WINDOW_CYC(4096)) ccs_clock_sequencer_i (
        .clk(clk), .rst(rst), .master_clock_in(mclk), .reset_low_pin(rlp),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_clock_i(fpin), .frame_clock_o(fo),
        .frame_clock_oe(foe), .bit_clock_i(bpin), .bit_clock_o(bo), .bit_clock_oe(boe),
        .master_clock_out(mco), .master_clock_out_valid(mcov), .pll_locked(lock),
        .normal_op(nop), .audio_format_sel(afs), .sample_rate_sel(srs),
        .pll_ref_freq_sel(prs), .dac_word(dw), .dac_code(dc), .adc_word(aw),
        .serial_data_out(sdo), .adc_init_busy(busy));
    ccs_host_clk_model ccs_host_clk_model_i (.slv_en(slv), .frame_o(fo), .frame_oe(foe),
        .bit_o(bo), .bit_oe(boe), .mclk(mclk), .frame_pin(fpin), .bit_pin(bpin));
    // ****************************************
    // tasks
    // ****************************************
    task automatic results;
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic wait_sig(ref logic s, input logic v, input int mx);
        n = 0;
        while (s !== v && n < mx) begin
            tick(1);
            n++;
        end
    endtask
    task automatic restart(input logic s);
        @(posedge clk);
        rst <= 1'b1;
        slv <= s;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask
    always @(posedge fpin) begin
        if (busy === 1'b1) begin
            frc++;
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #3200000;
        fails++;
        results();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst, rlp, reg_wr, reg_rd, slv, reg_addr, reg_wdata, dw, aw} = {1'b1, 1'b0, 67'h0};
        repeat (5) @(posedge clk);
        rlp <= 1'b1;
        rst <= 1'b0;
        for (int a = 0; a < 5; a++) begin
            rd((a == 4) ? 8'h10 : a[7:0]);
            `CHK("reg default", 8'h00, rv)
        end
        for (int i = 0; i < 5; i++) begin
            restart(sl[i]);
            wr(`CCS_ADDR_PLL, {1'b0, cm[i], i[3:0]});
            wr(`CCS_ADDR_MODE, {6'h02, i[1:0]});
            wr(`CCS_ADDR_POWER, 8'h01);
            `CHK("fields", {i[1:0], i[3:0]}, {afs, prs})
            if (lim[i] == 0) begin
                wait_sig(nop, 1'b1, 3000);
                `CHK("ext normal", 1'b1, nop)
                `CHK("ext lock", 1'b0, lock)
            end else begin
                wr(`CCS_ADDR_POWER, 8'h03);
                `CHK("mco early", 1'b0, mcov)
                wait_sig(lock, 1'b1, 3000);
                `CHK("lock time", 1'b1, (n >= lim[i] - 2) && (n <= lim[i] + 40))
                `CHK("mco valid", 1'b1, mcov)
                tick(8);
                `CHK("normal", 1'b1, nop)
                `CHK("frame drive", i == 0, foe)
                @(posedge mco);
                t0 = $realtime;
                @(posedge mco);
                `CHK("mco period", 128, int'($realtime - t0))
                @(posedge bpin);
                t0 = $realtime;
                @(posedge bpin);
                `CHK("bit period", (i == 0) ? 256 : 128, int'($realtime - t0))
            end
        end
        @(posedge clk);
        rlp <= 1'b0;
        repeat (5) @(posedge clk);
        rlp <= 1'b1;
        tick(6);
        rd(`CCS_ADDR_MODE);
        `CHK("pin reset", 8'h00, rv)
        restart(1'b0);
        wr(`CCS_ADDR_POWER, 8'h02);
        rd(`CCS_ADDR_STATUS);
        `CHK("seq err", 1'b1, rv[`CCS_STAT_SEQERR_BIT])
        tick(LK_M + 50);
        `CHK("no pll", 1'b0, lock)
        wr(`CCS_ADDR_STATUS, 8'h10);
        rd(`CCS_ADDR_STATUS);
        `CHK("seq clear", 1'b0, rv[`CCS_STAT_SEQERR_BIT])
        restart(1'b1);
        wr(`CCS_ADDR_PLL, 8'h40);
        wr(`CCS_ADDR_POWER, 8'h01);
        wait_sig(nop, 1'b1, 3000);
        wr(`CCS_ADDR_POWER, 8'h09);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            dw <= dwv[k];
            tick(3);
            `CHK("dac code", dcv[k], dc)
        end
        for (int f = 0; f < 2; f++) begin
            wr(`CCS_ADDR_RATE, f ? 8'h17 : 8'h05);
            wr(`CCS_ADDR_POWER, 8'h05);
            frc = 0;
            tick(1);
            `CHK("init busy", 1'b1, busy)
            `CHK("rate sel", f ? 4'h7 : 4'h5, srs)
            wait_sig(busy, 1'b0, 40000);
            n = f ? 267 : 1059;
            `CHK("init frames", 1'b1, (frc >= n - 1) && (frc <= n + 1))
            @(posedge clk);
            aw <= f ? 24'hA5A5A5 : 24'h5A5A5A;
            tick(2);
            `CHK("adc data", f ? 24'hA5A5A5 : 24'h5A5A5A, sdo)
            wr(`CCS_ADDR_POWER, 8'h01);
        end
        results();
    end
endmodule
`default_nettype wire
